// *** verilog/dvr_volume_regs.sv ***
// digital volume register bank: serial writes, staged latches, simultaneous apply
`timescale 1ns/10ps
`include "dvr_regs.svh"

module dvr_volume_regs
#(
   parameter int NCH      = 6,
   parameter int SAMPLE_W = 24
)
(
   input  wire logic                     i_clk,
   input  wire logic                     i_rst,
   input  wire logic                     i_ce,
   input  wire logic                     i_sclk_pin,
   input  wire logic                     i_sdin_pin,
   input  wire logic                     i_latch_pin,
   input  wire logic                     i_frame_strobe,
   input  wire logic                     i_smp_vld,
   input  wire logic [NCH*SAMPLE_W-1:0]  i_smp,
   output logic                          o_smp_vld,
   output logic [NCH*SAMPLE_W-1:0]       o_smp,
   output logic [NCH*8-1:0]              o_applied_codes,
   output logic [NCH*8-1:0]              o_staged_codes,
   output logic [7:0]                    o_all_channel_atten_code,
   output logic                          o_soft_reset_hold
);
   import dvr_pkg::*;

   initial
   begin
      if (NCH != 6) $error("channel count must be six to match the address map");
      if (SAMPLE_W < 8 || SAMPLE_W > 32) $error("sample width out of range");
   end

   // ****************************************************************
   // serial word intake
   // ****************************************************************
   logic                    word_vld;
   logic [`DVR_WORD_W-1:0]  word;
   dvr_addr_t               waddr;
   dvr_data_t               wdata;
   logic                    wupd;

   dvr_serial_rx #(.WORD_W(`DVR_WORD_W)) u_rx
   (
      .i_clk       (i_clk),
      .i_rst       (i_rst),
      .i_ce        (i_ce),
      .i_sclk_pin  (i_sclk_pin),
      .i_sdin_pin  (i_sdin_pin),
      .i_latch_pin (i_latch_pin),
      .o_word_vld  (word_vld),
      .o_word      (word)
   );

   // split word into address and data fields
   assign waddr = word[`DVR_ADDR_MSB:`DVR_ADDR_LSB];
   assign wdata = word[`DVR_DATA_W-1:0];
   assign wupd  = wdata[`DVR_UPD_BIT];

   // ****************************************************************
   // address decode
   // ****************************************************************
   logic [NCH-1:0] ch_hit;
   logic           all_hit;
   logic           rst_hit;
   logic           any_hit;

   always_comb
   begin
      ch_hit = '0;
      ch_hit[0] = (waddr == `DVR_OFF_LEFT1);
      ch_hit[1] = (waddr == `DVR_OFF_RIGHT1);
      ch_hit[2] = (waddr == `DVR_OFF_LEFT2);
      ch_hit[3] = (waddr == `DVR_OFF_RIGHT2);
      ch_hit[4] = (waddr == `DVR_OFF_LEFT3);
      ch_hit[5] = (waddr == `DVR_OFF_RIGHT3);
      all_hit = (waddr == `DVR_OFF_ALL);
      rst_hit = (waddr == `DVR_OFF_SWRST);
      any_hit = (|ch_hit) || all_hit;
   end

   // ****************************************************************
   // software reset hold
   // ****************************************************************
   logic hold_q;

   // set by a write to 1F, released by the next completed write
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         hold_q <= 1'b0;
      else if (i_ce && word_vld)
         hold_q <= rst_hit;
   end

   assign o_soft_reset_hold = hold_q;

   // ****************************************************************
   // staged and pending-apply state
   // ****************************************************************
   logic [7:0] staged_q [NCH];
   logic [7:0] applied_q [NCH];
   logic [7:0] all_q;
   logic       pend_q;
   logic       wr_ok;

   // writes during the hold only release it
   assign wr_ok = i_ce && word_vld && !hold_q && !rst_hit;

   // all-channel code register
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         all_q <= `DVR_CODE_RST;
      else if (i_ce && word_vld && rst_hit)
         all_q <= `DVR_CODE_RST;
      else if (wr_ok && all_hit)
         all_q <= wdata[`DVR_CODE_MSB:0];
   end

   // apply request waits for the next sample boundary
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         pend_q <= 1'b0;
      else if (i_ce && word_vld && rst_hit)
         pend_q <= 1'b0;
      else if (wr_ok && any_hit && wupd)
         pend_q <= 1'b1;
      else if (i_ce && i_frame_strobe)
         pend_q <= 1'b0;
   end

   // per-channel staged and applied codes
   genvar g;
   generate
      for (g = 0; g < NCH; g++)
      begin : g_ch
         always_ff @(posedge i_clk)
         begin
            if (i_rst)
               staged_q[g] <= `DVR_CODE_RST;
            else if (i_ce && word_vld && rst_hit)
               staged_q[g] <= `DVR_CODE_RST;
            else if (wr_ok && ch_hit[g])
               staged_q[g] <= wdata[`DVR_CODE_MSB:0];
            else if (wr_ok && all_hit)
               staged_q[g] <= wdata[`DVR_CODE_MSB:0];
         end

         always_ff @(posedge i_clk)
         begin
            if (i_rst)
               applied_q[g] <= `DVR_CODE_RST;
            else if (i_ce && word_vld && rst_hit)
               applied_q[g] <= `DVR_CODE_RST;
            else if (i_ce && i_frame_strobe && pend_q)
               applied_q[g] <= staged_q[g];
         end

         dvr_gain_stage #(.SAMPLE_W(SAMPLE_W)) u_gain
         (
            .i_clk     (i_clk),
            .i_rst     (i_rst),
            .i_ce      (i_ce),
            .i_smp_vld (i_smp_vld && !hold_q),
            .i_smp     (i_smp[g*SAMPLE_W +: SAMPLE_W]),
            .i_code    (applied_q[g]),
            .o_smp_vld (),
            .o_smp     (o_smp[g*SAMPLE_W +: SAMPLE_W])
         );

         assign o_applied_codes[g*8 +: 8] = applied_q[g];
         assign o_staged_codes[g*8 +: 8]  = staged_q[g];
      end
   endgenerate

   // sample valid is registered once, in step with the registered gain stage output
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         o_smp_vld <= 1'b0;
      else if (i_ce)
         o_smp_vld <= i_smp_vld && !hold_q;
   end

   assign o_all_channel_atten_code = all_q;

   // ****************************************************************
   // checks
   // ****************************************************************
   a_reset_defaults: assert property (@(posedge i_clk)
      $fell(i_rst) |-> (applied_q[0] == 8'hFF && staged_q[5] == 8'hFF && all_q == 8'hFF))
      else $error("codes not at default after reset");

   a_stage_no_apply: assert property (@(posedge i_clk) disable iff (i_rst)
      (wr_ok && ch_hit[0] && !wupd && !pend_q && !i_frame_strobe)
      |=> (applied_q[0] == $past(applied_q[0])))
      else $error("staged write changed applied code");

   a_stage_store: assert property (@(posedge i_clk) disable iff (i_rst)
      (wr_ok && ch_hit[2]) |=> (staged_q[2] == $past(wdata[7:0])))
      else $error("channel code not stored");

   a_update_pend: assert property (@(posedge i_clk) disable iff (i_rst)
      (wr_ok && ch_hit[1] && wupd) |=> pend_q)
      else $error("update bit did not request apply");

   a_apply_boundary: assert property (@(posedge i_clk) disable iff (i_rst)
      (applied_q[3] != $past(applied_q[3])) |-> ($past(i_frame_strobe) || $past(rst_hit)))
      else $error("applied code changed off a sample boundary");

   a_all_overwrite: assert property (@(posedge i_clk) disable iff (i_rst)
      (wr_ok && all_hit) |=> (staged_q[4] == all_q && staged_q[0] == all_q))
      else $error("all-channel write did not stage every channel");

   a_swrst_default: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && word_vld && rst_hit) |=> (hold_q && applied_q[5] == 8'hFF && all_q == 8'hFF))
      else $error("software reset did not restore defaults");

   a_hold_release: assert property (@(posedge i_clk) disable iff (i_rst)
      (hold_q && i_ce && word_vld && !rst_hit) |=> (!hold_q && staged_q[1] == $past(staged_q[1])))
      else $error("hold not released cleanly by next write");

   a_mute_code: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && i_smp_vld && !hold_q && applied_q[0] == 8'h00)
      |=> (o_smp[SAMPLE_W-1:0] == '0))
      else $error("code zero did not mute");
endmodule

// *** pkg/dvr_regs.svh ***
// register offsets, field positions, reset values and step size for the digital volume block
`ifndef DVR_REGS_SVH
`define DVR_REGS_SVH
`define DVR_ADDR_W        7
`define DVR_DATA_W        9
`define DVR_WORD_W        16
`define DVR_ADDR_MSB      15
`define DVR_ADDR_LSB      9
`define DVR_UPD_BIT       8
`define DVR_CODE_MSB      7
`define DVR_OFF_LEFT1     7'h00
`define DVR_OFF_RIGHT1    7'h01
`define DVR_OFF_LEFT2     7'h04
`define DVR_OFF_RIGHT2    7'h05
`define DVR_OFF_LEFT3     7'h06
`define DVR_OFF_RIGHT3    7'h07
`define DVR_OFF_ALL       7'h08
`define DVR_OFF_SWRST     7'h1F
`define DVR_CODE_RST      8'hFF
`define DVR_CODE_MUTE     8'h00
`define DVR_STEP_MDB      5
`endif

// *** pkg/dvr_pkg.sv ***
// types shared by the digital volume register block
package dvr_pkg;
   typedef logic [7:0] dvr_code_t;
   typedef logic [6:0] dvr_addr_t;
   typedef logic [8:0] dvr_data_t;
   typedef enum logic [2:0]
   {
      DVR_IDLE  = 3'b001,
      DVR_SHIFT = 3'b010,
      DVR_DONE  = 3'b100
   } dvr_ser_st_t;
endpackage

// *** verilog/dvr_serial_rx.sv ***
// three-wire serial control receiver: shifts 16-bit words, msb first
`timescale 1ns/10ps
module dvr_serial_rx
#(
   parameter int WORD_W = 16
)
(
   input  wire logic              i_clk,
   input  wire logic              i_rst,
   input  wire logic              i_ce,
   input  wire logic              i_sclk_pin,
   input  wire logic              i_sdin_pin,
   input  wire logic              i_latch_pin,
   output logic                   o_word_vld,
   output logic [WORD_W-1:0]      o_word
);
   import dvr_pkg::*;

   initial
   begin
      if (WORD_W < 2) $error("word width too small");
   end

   // two-stage synchronisers for all three pins
   logic [2:0] meta_q;
   logic [2:0] sync_q;
   logic       sclk_prev_q;
   logic       latch_prev_q;
   logic [WORD_W-1:0] shift_q;
   dvr_ser_st_t       st_q;

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         meta_q <= 3'h0;
         sync_q <= 3'h0;
         sclk_prev_q <= 1'b0;
         latch_prev_q <= 1'b0;
      end
      else if (i_ce)
      begin
         meta_q <= {i_latch_pin, i_sdin_pin, i_sclk_pin};
         sync_q <= meta_q;
         sclk_prev_q <= sync_q[0];
         latch_prev_q <= sync_q[2];
      end
   end

   // shift on rising clock edge, complete word on rising latch
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         shift_q <= '0;
         st_q <= DVR_IDLE;
         o_word <= '0;
         o_word_vld <= 1'b0;
      end
      else if (i_ce)
      begin
         o_word_vld <= 1'b0;
         unique case (st_q)
            DVR_IDLE, DVR_SHIFT:
            begin
               if (sync_q[0] && !sclk_prev_q)
               begin
                  shift_q <= {shift_q[WORD_W-2:0], sync_q[1]};
                  st_q <= DVR_SHIFT;
               end
               if (sync_q[2] && !latch_prev_q && st_q == DVR_SHIFT)
               begin
                  o_word <= shift_q;
                  o_word_vld <= 1'b1;
                  st_q <= DVR_DONE;
               end
            end
            DVR_DONE:
            begin
               st_q <= DVR_IDLE;
            end
            default:
            begin
               st_q <= DVR_IDLE;
            end
         endcase
      end
   end
endmodule

// *** verilog/dvr_gain_stage.sv ***
// per-channel gain applied to one sample at a time, 0.5 dB code steps
`timescale 1ns/10ps
`include "dvr_regs.svh"
module dvr_gain_stage
#(
   parameter int SAMPLE_W = 24
)
(
   input  wire logic                 i_clk,
   input  wire logic                 i_rst,
   input  wire logic                 i_ce,
   input  wire logic                 i_smp_vld,
   input  wire logic [SAMPLE_W-1:0]  i_smp,
   input  wire dvr_pkg::dvr_code_t   i_code,
   output logic                      o_smp_vld,
   output logic [SAMPLE_W-1:0]       o_smp
);
   import dvr_pkg::*;

   // twelve-step table of 0.5 dB fractions in q15, whole 6 dB steps by shift
   logic [15:0] frac;
   logic [7:0]  atten;
   logic [4:0]  shr;
   logic signed [SAMPLE_W+16:0] prod;

   always_comb
   begin
      atten = `DVR_CODE_RST - i_code;
      shr = 5'(atten / 8'd12);
      unique case (4'(atten % 8'd12))
         4'h0: frac = 16'h8000;
         4'h1: frac = 16'h78D6;
         4'h2: frac = 16'h7214;
         4'h3: frac = 16'h6BB2;
         4'h4: frac = 16'h65AC;
         4'h5: frac = 16'h5FFC;
         4'h6: frac = 16'h5A9D;
         4'h7: frac = 16'h558C;
         4'h8: frac = 16'h50C3;
         4'h9: frac = 16'h4C3E;
         4'hA: frac = 16'h47FA;
         default: frac = 16'h43F4;
      endcase
      prod = ($signed(i_smp) * $signed({1'b0, frac})) >>> 15;
      prod = prod >>> shr;
   end

   // registered sample, code 00 mutes outright
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_smp <= '0;
         o_smp_vld <= 1'b0;
      end
      else if (i_ce)
      begin
         o_smp_vld <= i_smp_vld;
         if (i_smp_vld)
         begin
            if (i_code == `DVR_CODE_MUTE)
               o_smp <= '0;
            else
               o_smp <= prod[SAMPLE_W-1:0];
         end
      end
   end
endmodule

// *** tb/dvr_host_model.sv ***
// host side model that shifts 16-bit control words onto the three serial pins
`timescale 1ns/10ps
module dvr_host_model
(
   input  wire logic i_clk,
   output logic      o_sclk,
   output logic      o_sdin,
   output logic      o_latch
);
   // pins idle low at time zero
   initial
   begin
      o_sclk = 1'b0;
      o_sdin = 1'b0;
      o_latch = 1'b0;
   end

   // four clocks per half period so the pin synchroniser sees every edge
   task automatic half();
      repeat (4) @(negedge i_clk);
   endtask

   // one word, msb first, data set while the serial clock is low, then latch
   task automatic send(input logic [15:0] w);
      for (int b = 15; b >= 0; b--)
      begin
         o_sdin = w[b];
         half();
         o_sclk = 1'b1;
         half();
         o_sclk = 1'b0;
      end
      o_sdin = ~o_sdin; // released data line shows the inverse
      o_latch = 1'b1;
      half();
      o_latch = 1'b0;
      half();
   endtask
endmodule

// *** tb/dvr_volume_regs_test.sv ***
// self-checking bench for the digital volume register bank
`timescale 1ns/10ps
`include "dvr_regs.svh"
module dvr_volume_regs_test;
   import dvr_pkg::*;

   localparam dvr_addr_t ADDRS [6] = '{`DVR_OFF_LEFT1, `DVR_OFF_RIGHT1, `DVR_OFF_LEFT2,
                                       `DVR_OFF_RIGHT2, `DVR_OFF_LEFT3, `DVR_OFF_RIGHT3};
   localparam logic [143:0] UNITY = {6{24'h100000}};

   logic         i_clk;
   logic         i_rst;
   logic         i_frame_strobe;
   logic         i_smp_vld;
   logic [143:0] i_smp;
   logic         sclk;
   logic         sdin;
   logic         latch;
   logic         o_smp_vld;
   logic [143:0] o_smp;
   logic [47:0]  o_applied_codes;
   logic [47:0]  o_staged_codes;
   logic [7:0]   o_all_channel_atten_code;
   logic         o_soft_reset_hold;
   logic [47:0]  exp_st;
   logic [47:0]  exp_ap;
   int           err_total;
   int           comparisons;
   int           cyc;

   dvr_host_model host (.i_clk(i_clk), .o_sclk(sclk), .o_sdin(sdin), .o_latch(latch));

   dvr_volume_regs dut
   (
      .i_clk                    (i_clk),
      .i_rst                    (i_rst),
      .i_ce                     (1'b1),
      .i_sclk_pin               (sclk),
      .i_sdin_pin               (sdin),
      .i_latch_pin              (latch),
      .i_frame_strobe           (i_frame_strobe),
      .i_smp_vld                (i_smp_vld),
      .i_smp                    (i_smp),
      .o_smp_vld                (o_smp_vld),
      .o_smp                    (o_smp),
      .o_applied_codes          (o_applied_codes),
      .o_staged_codes           (o_staged_codes),
      .o_all_channel_atten_code (o_all_channel_atten_code),
      .o_soft_reset_hold        (o_soft_reset_hold)
   );

   // 100 MHz clock
   initial
   begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   // verdict and end of run
   task automatic stop_test();
      if (err_total == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // hang guard, well above the few thousand cycles the sequence needs
   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc == 10000)
      begin
         err_total++;
         stop_test();
      end
   end

   // compare one value and count it
   task automatic chk(input logic [143:0] got, input logic [143:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
         err_total++;
      end
   endtask

   // one control word, then time for sync, word valid and store
   task automatic wr(input dvr_addr_t a, input logic u, input dvr_code_t c);
      host.send({a, u, c});
      repeat (8) @(negedge i_clk);
   endtask

   // one-cycle sample boundary pulse
   task automatic strobe();
      i_frame_strobe = 1'b1;
      @(negedge i_clk);
      i_frame_strobe = 1'b0;
      repeat (2) @(negedge i_clk);
   endtask

   // one sample set through the gain path; v says whether valid should appear
   task automatic smp(input logic [143:0] exp, input logic v);
      int n;
      i_smp_vld = 1'b1;
      @(negedge i_clk);
      i_smp_vld = 1'b0;
      n = 0;
      while (o_smp_vld !== 1'b1 && n < 4)
      begin
         @(negedge i_clk);
         n++;
      end
      chk(o_smp_vld, v);
      if (v)
         chk(o_smp, exp);
   endtask

   // main sequence
   initial
   begin
      i_rst = 1'b1;
      i_frame_strobe = 1'b0;
      i_smp_vld = 1'b0;
      i_smp = UNITY;
      err_total = 0;
      comparisons = 0;
      cyc = 0;
      exp_st = {6{`DVR_CODE_RST}};
      exp_ap = exp_st;
      repeat (6) @(negedge i_clk);
      i_rst = 1'b0;
      @(negedge i_clk);
      chk(o_applied_codes, exp_ap);
      chk(o_staged_codes, exp_st);
      chk(o_all_channel_atten_code, `DVR_CODE_RST);
      chk(o_soft_reset_hold, 1'b0);
      smp(UNITY, 1'b1);
      // distinct staged codes per channel, applied ones untouched
      for (int g = 0; g < 6; g++)
      begin
         wr(ADDRS[g], 1'b0, dvr_code_t'(8'h10 + g));
         exp_st[g*8+:8] = dvr_code_t'(8'h10 + g);
      end
      strobe();
      chk(o_staged_codes, exp_st);
      chk(o_applied_codes, exp_ap);
      // update on the last channel waits for the sample boundary
      wr(`DVR_OFF_RIGHT3, 1'b1, 8'h01);
      exp_st[47:40] = 8'h01;
      chk(o_applied_codes, exp_ap);
      strobe();
      exp_ap = exp_st;
      chk(o_applied_codes, exp_ap);
      // the update bit is not remembered for later writes
      wr(`DVR_OFF_LEFT1, 1'b0, `DVR_CODE_MUTE);
      exp_st[7:0] = `DVR_CODE_MUTE;
      strobe();
      chk(o_applied_codes, exp_ap);
      chk(o_staged_codes, exp_st);
      // unmapped address changes nothing
      wr(7'h02, 1'b1, 8'h55);
      strobe();
      chk(o_staged_codes, exp_st);
      chk(o_applied_codes, exp_ap);
      // all-channel code stages everywhere, then applies everywhere
      wr(`DVR_OFF_ALL, 1'b0, 8'h40);
      exp_st = {6{8'h40}};
      strobe();
      chk(o_staged_codes, exp_st);
      chk(o_all_channel_atten_code, 8'h40);
      chk(o_applied_codes, exp_ap);
      wr(`DVR_OFF_ALL, 1'b1, `DVR_CODE_MUTE);
      exp_st = '0;
      strobe();
      exp_ap = exp_st;
      chk(o_applied_codes, exp_ap);
      smp('0, 1'b1);
      // twelve half-dB steps halve the sample exactly
      wr(`DVR_OFF_ALL, 1'b1, 8'hF3);
      exp_st = {6{8'hF3}};
      strobe();
      exp_ap = exp_st;
      chk(o_applied_codes, exp_ap);
      smp({6{24'h080000}}, 1'b1);
      // software reset restores defaults and holds until the next write
      wr(`DVR_OFF_SWRST, 1'b0, 8'h00);
      exp_st = {6{`DVR_CODE_RST}};
      exp_ap = exp_st;
      chk(o_applied_codes, exp_ap);
      chk(o_staged_codes, exp_st);
      chk(o_all_channel_atten_code, `DVR_CODE_RST);
      chk(o_soft_reset_hold, 1'b1);
      smp('0, 1'b0);
      wr(`DVR_OFF_LEFT2, 1'b1, 8'h33);
      strobe();
      chk(o_soft_reset_hold, 1'b0);
      chk(o_staged_codes, exp_st);
      chk(o_applied_codes, exp_ap);
      smp(UNITY, 1'b1);
      stop_test();
   end
endmodule
